// file: verification/ccsu_master.sv
// Bus master standing in for the CPU or DMA controller
module ccsu_master (
  // Clock and answer
  input wire logic ref_clk,
  input wire logic hready,
  input wire logic [ccsu_pkg::AHB_DW-1:0] hrdata,
  // Request
  output logic hsel,
  output logic [ccsu_pkg::AHB_AW-1:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [ccsu_pkg::AHB_DW-1:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccsu_pkg::*;
  // Idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0000_0000;
  end
  // One single transfer, each phase held until hready is high
  // Transfers issued in call order
  task automatic xfer(input logic [31:0] a, input logic w,
    input logic [2:0] sz, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= sz;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
endmodule

// file: verification/ccsu_top_asserts.sv
// Port-level checks of the signature unit's bus slave
module ccsu_top_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Request side
  input wire logic hsel,
  input wire logic [ccsu_pkg::AHB_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // Answer side
  input wire logic [ccsu_pkg::AHB_DW-1:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccsu_pkg::*;
  // Accepted address phase
  logic taken;
  // Register index of the address
  logic [2:0] idx;
  assign taken = hsel && htrans[1] && hready;
  assign idx = haddr[IDX_MSB:IDX_LSB];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_okay; hresp == HRESP_OKAY; endproperty
  a_okay: assert property (p_okay)
    else $error("response not OKAY");
  property p_upper; hreadyout |-> hrdata[31:16] == '0; endproperty
  a_upper: assert property (p_upper)
    else $error("upper read half not zero");
  property p_wait; taken |=> !hreadyout; endproperty
  a_wait: assert property (p_wait)
    else $error("no wait cycle after address phase");
  property p_bound; !hreadyout |-> ##[0:30] hreadyout; endproperty
  a_bound: assert property (p_bound)
    else $error("wait state too long");
  property p_hold; !hreadyout ##1 !hreadyout |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved while waiting");
  property p_wrzero;
    (taken && hwrite) ##1 !hreadyout ##1 hreadyout |-> hrdata == '0;
  endproperty
  a_wrzero: assert property (p_wrzero)
    else $error("write completion data not zero");
  property p_fast;
    taken && !hwrite && idx != IDX_SEED_RESULT &&
      idx != IDX_RESULT_BITREV |=> !hreadyout ##1 hreadyout;
  endproperty
  a_fast: assert property (p_fast)
    else $error("data input read not one wait cycle");
  property p_rst; $rose(rst_n) |-> hreadyout && hrdata == '0; endproperty
  a_rst: assert property (p_rst)
    else $error("bus answer wrong after reset");
endmodule

// file: verification/ccsu_top_bench.sv
// Compare helper: counts and reports
`define CHK(nm, ex, got) begin \
  checks++; \
  if ((got) !== (ex)) begin \
    errorCnt++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); \
  end \
end
module ccsu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ccsu_pkg::*;
  // Bus and clock wiring
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  // Counters
  int errorCnt = 0;
  int checks = 0;
  int cyc = 0;
  // Reference passes: port and lane, width, expected signature
  logic [31:0] mAddr [5] = '{32'h8, 32'h8, 32'h1, 32'h0, 32'h0};
  logic mWord [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [15:0] mExp [5] = '{16'h29B1, 16'h29B1, 16'h89F6, 16'h89F6,
    16'h89F6};
  ccsu_top dut_u (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
  ccsu_master mst_u (.ref_clk, .hready(hreadyout), .hrdata, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata);
  // Free-running clock
  initial forever #2.5 ref_clk = ~ref_clk;
  // Mirror of sixteen bits
  function automatic logic [15:0] mir(input logic [15:0] v);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = v[15 - i];
    return r;
  endfunction
  // Register write
  task automatic wr(input logic [31:0] a, input logic [2:0] sz,
    input logic [15:0] d);
    mst_u.xfer(a, 1'b1, sz, {2{d}}, rdata);
  endtask
  // Register read and compare
  task automatic rd(input logic [31:0] a, input logic [15:0] ex,
    input string nm);
    mst_u.xfer(a, 1'b0, 3'h2, 32'h0000_0000, rdata);
    `CHK(nm, {16'h0000, ex}, rdata)
  endtask
  // Verdict and end of run
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Cycle ceiling against a hung handshake
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errorCnt++;
      endOfTest();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(32'h0000_0000, 16'h0000, "data in reset");
    rd(32'h0000_0008, 16'h0000, "reverse port reset");
    rd(32'h0000_0010, 16'hFFFF, "result reset");
    rd(32'h0000_0018, 16'hFFFF, "mirror reset");
    rd(32'h0000_0004, 16'h0000, "unmapped");
    wr(32'h0000_0010, 3'h2, 16'h1234);
    rd(32'h0000_0010, 16'h1234, "seed readback");
    rd(32'h0000_0018, mir(16'h1234), "mirror of seed");
    wr(32'h0000_0018, 3'h2, 16'h5555);
    rd(32'h0000_0018, mir(16'h1234), "read-only mirror");
    wr(32'h0000_0011, 3'h0, 16'hABAB);
    rd(32'h0000_0010, 16'hAB34, "seed high byte");
    foreach (mAddr[m]) begin
      wr(32'h0000_0010, 3'h2, 16'hFFFF);
      if (mWord[m]) begin
        for (int i = 0; i < 8; i += 2) begin
          wr(mAddr[m], 3'h2, {8'h32 + 8'(i), 8'h31 + 8'(i)});
        end
      end else begin
        for (int i = 0; i < 8; i++) begin
          wr(mAddr[m], 3'h0, {2{8'h31 + 8'(i)}});
        end
      end
      wr(mAddr[m], 3'h0, 16'h3939);
      rd(32'h0000_0010, mExp[m], "signature");
      rd(32'h0000_0018, mir(mExp[m]), "mirrored signature");
    end
    rd(32'h0000_0008, 16'h3839, "data in via reverse port");
    wr(32'h0000_0000, 3'h2, mir(16'h89F6));
    rd(32'h0000_0010, 16'h0000, "zero signature");
    rd(32'h0000_0018, 16'h0000, "zero mirror");
    endOfTest();
  end
endmodule
// Port checker beside the design's top
bind ccsu_top ccsu_top_asserts chk_u (.ref_clk, .rst_n, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp);

// file: verilog/ccsu_pkg.sv
// Shared constants, types and helpers of the CRC16 signature unit
package ccsu_pkg;

  // Bus widths
  localparam int unsigned AHB_AW = 32;
  localparam int unsigned AHB_DW = 32;

  // Register width and byte width
  localparam int unsigned REG_W = 16;
  localparam int unsigned BYTE_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA_IN = 3'h0;
  localparam logic [2:0] IDX_DATA_IN_BITREV = 3'h2;
  localparam logic [2:0] IDX_SEED_RESULT = 3'h4;
  localparam logic [2:0] IDX_RESULT_BITREV = 3'h6;

  // Address slice that holds the register index
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 4;

  // Reset values of the registers
  localparam logic [15:0] DATA_IN_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'hFFFF;

  // Generator polynomial x^16 + x^12 + x^5 + 1
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // AHB encodings used by the slave
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic HRESP_OKAY = 1'h0;

  // Depth of the data FIFO
  localparam int unsigned FIFO_DEPTH = 8;

  // One queued data write: payload, byte-reverse flag, size and lane
  typedef struct packed {
    logic [15:0] data;
    logic rev;
    logic word;
    logic lane;
  } ccsu_entry_type;

  localparam int unsigned ENTRY_W = $bits(ccsu_entry_type);

  // Mirror the bits of one byte
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction

  // Mirror all sixteen bits of a word
  function automatic logic [15:0] rev16(input logic [15:0] w);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = w[15 - i];
    end
    return r;
  endfunction

endpackage

// file: verilog/ccsu_top.sv
// Data FIFO between the bus slave and the CRC engine
module ccsu_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  import ccsu_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  // Whole FIFO state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
    logic [PW-1:0] wrPtr;             // Next slot to fill
    logic [PW-1:0] rdPtr;             // Oldest slot
    logic [CW-1:0] count;             // Words held
  } ccsu_fifo_state_type;

  ccsu_fifo_state_type s_q;
  ccsu_fifo_state_type s_d;
  logic doPush;
  logic doPop;

  // Honest flags straight from the count
  assign inReady = (s_q.count != FULL_COUNT);
  assign outValid = (s_q.count != '0);
  assign outData = s_q.mem[s_q.rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // Next state: write, read and count bookkeeping
  always_comb begin
    s_d = s_q;
    // Store incoming word and advance write pointer
    if (doPush) begin
      s_d.mem[s_q.wrPtr] = inData;
      s_d.wrPtr = (s_q.wrPtr == LAST_PTR) ? '0 : s_q.wrPtr + 1'b1;
    end
    // Drop oldest word and advance read pointer
    if (doPop) begin
      s_d.rdPtr = (s_q.rdPtr == LAST_PTR) ? '0 : s_q.rdPtr + 1'b1;
    end
    // Count follows push and pop together
    if (doPush && !doPop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (doPop && !doPush) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// Function
// (RQ1) Seed write loads the running signature
// (RQ2) Master feeds data in reference order
// (RQ3) Each data write merges; result read waits
// (RQ4) Parallel byte step equals LSB-first serial
// (RQ5) Word: low byte first cycle, high second
// (RQ6) Single byte absorbed in one cycle
// (RQ7) Reverse-byte input mirrors each byte first
// (RQ8) Plain input passes bytes unchanged
// (RQ9) Appending mirrored checksum yields zero result
// (RQ10) Second result register shows mirrored signature
// (RQ11) Word or byte access, low/high aliases
// (RQ12) Register indices 00h, 02h, 04h, 06h
// (RQ13) Reset: data zero, results all ones
// (RQ14) Reverse-byte read returns plain data input
// (RQ15) Feedback taps bits 0, 4, 11, 15
// (RQ16) Seed readback returns the written value
// (RQ17) Mirrored result: bit fifteen at zero
// (RQ18) Polynomial 0x1021 gives standard reference values
module ccsu_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave request
  input wire logic hsel,
  input wire logic [ccsu_pkg::AHB_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [ccsu_pkg::AHB_DW-1:0] hwdata,
  input wire logic hready,
  // AHB-Lite slave answer
  output logic [ccsu_pkg::AHB_DW-1:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import ccsu_pkg::*;

  // Whole state of the unit
  typedef struct packed {
    logic hreadyOut;         // Low while a transfer waits
    logic [31:0] rdata;      // Read data of the finished transfer
    logic resp;              // Response, always OKAY
    logic [2:0] idx;         // Register index of pending transfer
    logic [1:0] lane;        // Byte address within the word
    logic write;             // Pending transfer is a write
    logic isByte;            // Pending transfer is a byte access
    logic [15:0] dataIn;     // Plain data input register
    logic [15:0] result;     // Running signature, normal order
    logic hiPend;            // High byte of a word still to go
    logic [7:0] hiByte;      // That high byte
    logic hiRev;             // That high byte needs mirroring
  } ccsu_state_type;

  // Reset image of the state
  localparam ccsu_state_type STATE_RESET = '{
    hreadyOut: 1'b1,
    rdata: '0,
    resp: HRESP_OKAY,
    idx: '0,
    lane: '0,
    write: 1'b0,
    isByte: 1'b0,
    dataIn: DATA_IN_RESET,
    result: RESULT_RESET,
    hiPend: 1'b0,
    hiByte: '0,
    hiRev: 1'b0
  };

  ccsu_state_type s_q;
  ccsu_state_type s_d;

  // FIFO hookup
  ccsu_entry_type pushEntry;  // Entry built from the bus write
  logic pushValid;            // Bus offers a data write
  logic pushReady;            // FIFO has room
  logic [ENTRY_W-1:0] popRaw; // Oldest entry, flat
  ccsu_entry_type popEntry;   // Oldest entry, typed
  logic popValid;             // FIFO holds an entry
  logic popReady;             // Engine can take an entry

  // Decode of the pending transfer
  logic addrPhase;  // New transfer offered this cycle
  logic waiting;    // A data phase is open
  logic isData;     // Targets either data input
  logic laneOk;     // Byte lane lies inside the 16-bit register
  logic drained;    // No data left to merge
  logic finish;     // Data phase completes this cycle
  logic [15:0] wrWord;  // Write value merged by byte lane

  // One byte step of the signature, serial equivalent in a loop.
  // The state is kept in normal order; the LSB-first shift runs on
  // the mirrored form, whose feedback with the mirrored polynomial
  // taps bits 0, 4, 11 and 15 when bit 0 is called the MSB.
  function automatic logic [15:0] crcByte(
    input logic [15:0] crc,
    input logic [7:0] b
  );
    logic [15:0] r;
    logic [15:0] polyRev;
    r = '0;
    // (RQ18) Generator 0x1021, mirrored
    polyRev = rev16(CRC_POLY);
    // (RQ15) Mirrored tap set
    r = rev16(crc) ^ {8'h00, b};
    // (RQ4) Eight serial shifts
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ polyRev) : (r >> 1);
    end
    // (RQ9) No final inversion, zero residue
    return rev16(r);
  endfunction

  // Byte as the engine sees it after the optional mirroring
  function automatic logic [7:0] feedByte(
    input logic [7:0] b,
    input logic rev
  );
    return rev ? rev8(b) : b;
  endfunction

  // Data FIFO sits between the bus and the engine
  ccsu_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushEntry),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popRaw)
  );

  assign popEntry = ccsu_entry_type'(popRaw);

  // Bus decode and FIFO handshake terms
  always_comb begin
    addrPhase = hsel && htrans[1] && hready;
    waiting = !s_q.hreadyOut;
    // (RQ12) Both data inputs feed the FIFO
    isData = (s_q.idx == IDX_DATA_IN) || (s_q.idx == IDX_DATA_IN_BITREV);
    // (RQ11) Only lanes 0 and 1 exist for byte access
    laneOk = !s_q.isByte || !s_q.lane[1];
    drained = !popValid && !s_q.hiPend;
    // Merge write data into a 16-bit value by lane
    wrWord = hwdata[15:0];
    if (s_q.isByte) begin
      wrWord = s_q.lane[0] ? {hwdata[15:8], s_q.dataIn[7:0]}
                           : {s_q.dataIn[15:8], hwdata[7:0]};
    end
    // FIFO entry for a data write
    pushEntry.data = hwdata[15:0];
    // (RQ7) Reverse-byte input marks entry for mirroring
    pushEntry.rev = (s_q.idx == IDX_DATA_IN_BITREV);
    pushEntry.word = !s_q.isByte;
    pushEntry.lane = s_q.lane[0];
    pushValid = waiting && s_q.write && isData && laneOk;
    // Engine takes a new entry only when no high byte is left
    popReady = !s_q.hiPend;
    // Completion: data writes wait for room, seed and results drain
    if (!waiting) begin
      finish = 1'b0;
    end else if (pushValid) begin
      finish = pushReady;
    end else if ((s_q.idx == IDX_SEED_RESULT) ||
                 (s_q.idx == IDX_RESULT_BITREV)) begin
      // (RQ3) Result access waits until all data merged
      finish = drained;
    end else begin
      finish = 1'b1;
    end
  end

  // Next state: bus slave and CRC engine
  always_comb begin
    s_d = s_q;
    s_d.resp = HRESP_OKAY;

    // Engine: finish the high byte of a word
    if (s_q.hiPend) begin
      // (RQ5) High byte in second cycle
      s_d.result = crcByte(s_q.result, feedByte(s_q.hiByte, s_q.hiRev));
      s_d.hiPend = 1'b0;
    end else if (popValid) begin
      if (popEntry.word) begin
        // (RQ5) Low byte in first cycle
        s_d.result = crcByte(s_q.result,
                             feedByte(popEntry.data[7:0], popEntry.rev));
        s_d.hiPend = 1'b1;
        s_d.hiByte = popEntry.data[15:8];
        s_d.hiRev = popEntry.rev;
      end else begin
        // (RQ6) Single byte in one cycle
        // (RQ8) Plain input keeps bit order
        s_d.result = crcByte(s_q.result, feedByte(
          popEntry.lane ? popEntry.data[15:8] : popEntry.data[7:0],
          popEntry.rev));
      end
    end

    // Bus: close a data phase
    if (finish) begin
      s_d.hreadyOut = 1'b1;
      s_d.rdata = '0;
      if (s_q.write) begin
        if (laneOk) begin
          // (RQ8) Plain input stores its value
          if (s_q.idx == IDX_DATA_IN) begin
            s_d.dataIn = wrWord;
          end
          // (RQ1) Seed loads the running signature
          if (s_q.idx == IDX_SEED_RESULT) begin
            s_d.result = s_q.isByte ?
              (s_q.lane[0] ? {hwdata[15:8], s_q.result[7:0]}
                           : {s_q.result[15:8], hwdata[7:0]})
              : hwdata[15:0];
          end
        end
      end else begin
        unique case (s_q.idx)
          // (RQ14) Both data inputs read the plain register
          IDX_DATA_IN, IDX_DATA_IN_BITREV: begin
            s_d.rdata = {16'h0000, s_q.dataIn};
          end
          // (RQ16) Seed readback
          IDX_SEED_RESULT: begin
            s_d.rdata = {16'h0000, s_q.result};
          end
          // (RQ10) Mirrored result register
          IDX_RESULT_BITREV: begin
            // (RQ17) Bit fifteen appears at bit zero
            s_d.rdata = {16'h0000, rev16(s_q.result)};
          end
          // Unmapped index reads zero
          default: begin
            s_d.rdata = '0;
          end
        endcase
      end
    end

    // Bus: take a new address phase
    if (addrPhase && (s_q.hreadyOut || finish)) begin
      s_d.hreadyOut = 1'b0;
      s_d.idx = haddr[IDX_MSB:IDX_LSB];
      s_d.lane = haddr[1:0];
      s_d.write = hwrite;
      // (RQ11) Byte access selects one alias
      s_d.isByte = (hsize == HSIZE_BYTE);
    end
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk) begin
    // (RQ13) Data zero, result all ones
    if (!rst_n) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from state flops
  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.hreadyOut;
  assign hresp = s_q.resp;

endmodule
